// File: logic/ucn_pkg.sv
package ucn_pkg;
	// ----------------------------------------
	// control pin levels and sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH, LVL_PROG} ucn_level_t;
	typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_PROG} ucn_state_t;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	localparam int CODE_W = 8;
	localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
	localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
	localparam logic [CODE_W-1:0] CODE_FACTORY = 8'h80;

	// ----------------------------------------
	// timing, clk_sys period in ns
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int REJ_US = 20;
	localparam int PROG_HOLD_US = 200;
	localparam int RECALL_MS = 10;
	localparam int PROG_MS = 100;
	// rejection is a longest time: round down
	localparam int REJ_CYC = (REJ_US * 1000) / CLK_PERIOD_NS;
	// programming hold is a least time: round up
	localparam int PROG_HOLD_CYC = (PROG_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECALL_CYC_DFLT = (RECALL_MS * 1000000) / CLK_PERIOD_NS;
	localparam int PROG_CYC_DFLT = (PROG_MS * 1000000) / CLK_PERIOD_NS;
	localparam int FILT_W = 12;
	localparam int TMR_W = 24;
endpackage

// File: logic/ucn_ctl_if.sv
`timescale 1ns/1ns
interface ucn_ctl_if;
	import ucn_pkg::*;
	ucn_level_t level;
	logic prog_req;
	modport filt (output level, output prog_req);
	modport core (input level, input prog_req);
endinterface

// File: logic/ucn_ctl_filter.sv
`timescale 1ns/1ns
module ucn_ctl_filter (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ctl_over_high,
	input wire logic ctl_under_low,
	input wire logic ctl_over_prog,
	ucn_ctl_if.filt ctl
);
	import ucn_pkg::*;

	typedef struct packed {
		ucn_level_t cand;
		logic [FILT_W-1:0] stable;
		ucn_level_t level;
		logic [FILT_W-1:0] prog_cnt;
		logic prog_req;
	} ucn_filt_t;

	localparam ucn_filt_t FILT_RST = '{cand: LVL_MID, stable: '0, level: LVL_MID, prog_cnt: '0, prog_req: 1'b0};
	localparam logic [FILT_W-1:0] REJ_LAST = FILT_W'(REJ_CYC);
	localparam logic [FILT_W-1:0] HOLD_LAST = FILT_W'(PROG_HOLD_CYC);

	ucn_filt_t s_r;
	ucn_filt_t s_nxt;
	ucn_level_t raw;

	// ----------------------------------------
	// level classification
	// ----------------------------------------
	function automatic ucn_level_t classify(input logic over_prog, input logic over_high, input logic under_low);
		if (over_prog) begin
			return LVL_PROG;
		end else if (over_high) begin
			return LVL_HIGH;
		end else if (under_low) begin
			return LVL_LOW;
		end
		return LVL_MID;
	endfunction

	always_comb begin
		raw = classify(ctl_over_prog, ctl_over_high, ctl_under_low); // [R22]
		s_nxt = s_r;
		s_nxt.prog_req = 1'b0;
		// a level must stand past the reject window before it is seen
		if (raw != s_r.cand) begin
			s_nxt.cand = raw;
			s_nxt.stable = '0;
		end else if (s_r.stable != REJ_LAST) begin
			s_nxt.stable = s_r.stable + 1'b1;
		end else begin
			s_nxt.level = s_r.cand; // [R7]
		end
		// program request: raised on the sample that completes the hold time
		if (raw != LVL_PROG) begin
			s_nxt.prog_cnt = '0;
		end else if (s_r.prog_cnt != HOLD_LAST) begin
			s_nxt.prog_cnt = s_r.prog_cnt + 1'b1;
			s_nxt.prog_req = (s_r.prog_cnt + 1'b1) == HOLD_LAST; // [R12]
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= FILT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ctl.level = s_r.level;
	assign ctl.prog_req = s_r.prog_req;
endmodule

// File: logic/ucn_core.sv
`timescale 1ns/1ns
// Contract
// [R1] high excursion returning to middle decrements
// [R2] low excursion returning to middle increments
// [R3] counter saturates at both ends, never wraps
// [R4] code 0 to 255, 0 highest output
// [R5] count only while count enable high
// [R6] undriven control pin biased to mid level
// [R7] excursions under 20 us are rejected
// [R8] first pulse ignored after enable or program
// [R9] enable falling reloads counter within 10 ms; a fall during a store write reloads only once the write ends
// [R10] partner keeps inputs steady during reload
// [R11] undriven count enable reads low
// [R12] over 4.9 V beyond 200 us requests store
// [R13] store write done within 100 ms
// [R14] store copies current counter value
// [R15] power-up loads counter from store
// [R16] store holds mid-scale from factory
// [R17] partner drops enable before power removal
// [R18] partner floats pin, grounds enable to lock
// [R19] partner holds count excursions 200 us
// [R20] partner spaces pulses at least 10 us
// [R21] partner waits 50 us after enable rise
// [R22] programming level never counts up or down
// [R23] counter drives output converter continuously
module ucn_core #(
	parameter int unsigned RECALL_CYC = ucn_pkg::RECALL_CYC_DFLT,
	parameter int unsigned PROG_CYC = ucn_pkg::PROG_CYC_DFLT
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic count_enable,
	input wire logic ctl_over_high,
	input wire logic ctl_under_low,
	input wire logic ctl_over_prog,
	output logic [ucn_pkg::CODE_W-1:0] dcp_code,
	output logic nv_busy,
	output logic ctl_mid_bias_en,
	output logic ce_pulldown_en
);
	import ucn_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		ucn_state_t st;
		logic [CODE_W-1:0] code;
		logic [CODE_W-1:0] store;
		logic [TMR_W-1:0] timer;
		logic ignore;
		ucn_level_t exc;
		logic ce_q;
		logic busy;
	} ucn_core_t;

	// ----------------------------------------
	// reset values and timing
	// ----------------------------------------
	// store reset models the factory contents; a real part keeps it across power
	localparam ucn_core_t CORE_RST = '{
		st: ST_LOAD,
		code: CODE_FACTORY,
		store: CODE_FACTORY, // [R16]
		timer: '0,
		ignore: 1'b1,
		exc: LVL_MID,
		ce_q: 1'b0,
		busy: 1'b1
	};

	// prog request arrives after the hold, so the write gets the rest of the budget
	localparam logic [TMR_W-1:0] RECALL_LAST = TMR_W'(RECALL_CYC - 1);
	localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYC - PROG_HOLD_CYC - 1);

	ucn_core_t s_r;
	ucn_core_t s_nxt;

	// edge and pulse decodes, read by the sequencer
	logic ce_rise;
	logic ce_fall;
	logic pulse_end;

	// ----------------------------------------
	// control level filter
	// ----------------------------------------
	ucn_ctl_if ctl_bus ();

	ucn_ctl_filter u_filter (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.ctl_over_high(ctl_over_high),
		.ctl_under_low(ctl_under_low),
		.ctl_over_prog(ctl_over_prog),
		.ctl(ctl_bus.filt)
	);

	// ----------------------------------------
	// saturating step
	// ----------------------------------------
	function automatic logic [CODE_W-1:0] step(input logic [CODE_W-1:0] v, input logic up);
		if (up) begin
			return (v == CODE_MAX) ? v : v + 1'b1; // [R3]
		end
		return (v == CODE_MIN) ? v : v - 1'b1; // [R3]
	endfunction

	// only a swing out to one rail and back is a pulse
	function automatic logic is_rail(input ucn_level_t l);
		return (l == LVL_HIGH) || (l == LVL_LOW);
	endfunction

	// ----------------------------------------
	// enable edges and pulse end
	// ----------------------------------------
	assign ce_rise = !s_r.ce_q && count_enable;
	assign ce_fall = s_r.ce_q && !count_enable;
	assign pulse_end = (ctl_bus.level == LVL_MID) && is_rail(s_r.exc); // [R22]

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ce_q = count_enable;
		case (s_r.st)
			ST_LOAD: begin
				// the counter is untouched until the full reload time has passed
				s_nxt.busy = 1'b1;
				s_nxt.timer = s_r.timer + 1'b1;
				if (s_r.timer == RECALL_LAST) begin
					s_nxt.code = s_r.store; // [R9] [R15]
					s_nxt.st = ST_RUN;
					s_nxt.busy = 1'b0;
					s_nxt.timer = '0;
					s_nxt.ignore = 1'b1;
					s_nxt.exc = LVL_MID;
				end
			end
			ST_RUN: begin
				// an enable fall beats a pulse ending in the same cycle
				if (ce_fall) begin
					s_nxt.st = ST_LOAD; // [R9]
					s_nxt.busy = 1'b1;
					s_nxt.timer = '0;
				end else if (ce_rise) begin
					s_nxt.ignore = 1'b1; // [R8]
					s_nxt.exc = LVL_MID;
				end else if (count_enable) begin // [R5]
					// the write takes the counter as it stands now
					if (ctl_bus.prog_req) begin
						s_nxt.st = ST_PROG;
						s_nxt.busy = 1'b1;
						s_nxt.timer = '0;
						s_nxt.exc = LVL_PROG;
					end else begin
						case (ctl_bus.level)
							LVL_MID: begin
								if (pulse_end) begin
									if (s_r.ignore) begin
										s_nxt.ignore = 1'b0; // [R8]
									end else begin
										s_nxt.code = step(s_r.code, s_r.exc == LVL_LOW); // [R1] [R2]
									end
								end
								s_nxt.exc = LVL_MID;
							end
							LVL_HIGH, LVL_LOW: begin
								// a direct swing between rails is not a clean pulse
								if (s_r.exc == LVL_MID) begin
									s_nxt.exc = ctl_bus.level;
								end else if (is_rail(s_r.exc) && s_r.exc != ctl_bus.level) begin
									s_nxt.exc = LVL_PROG;
								end
							end
							default: begin
								s_nxt.exc = LVL_PROG; // [R22]
							end
						endcase
					end
				end
			end
			ST_PROG: begin
				// counter frozen while the write runs
				// an enable fall during the write reloads only after it
				s_nxt.timer = s_r.timer + 1'b1;
				if (s_r.timer == PROG_LAST) begin // [R13]
					s_nxt.store = s_r.code; // [R14]
					s_nxt.timer = '0;
					s_nxt.ignore = 1'b1; // [R8]
					s_nxt.exc = LVL_PROG; // [R22]
					s_nxt.st = count_enable ? ST_RUN : ST_LOAD;
					s_nxt.busy = !count_enable;
				end
			end
			default: begin
				s_nxt = CORE_RST;
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= CORE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// code comes straight from flip-flops, so no glitch reaches the converter
	assign dcp_code = s_r.code; // [R23] [R4]
	assign nv_busy = s_r.busy;
	// bias stays on with counting off, so a floated pin rests at mid
	assign ctl_mid_bias_en = 1'b1; // [R6]
	// the pulldown is what locks the setting when the enable pin is left open
	assign ce_pulldown_en = 1'b1; // [R11]
endmodule

// File: dv/ucn_core_asserts.sv
`timescale 1ns/1ns
module ucn_core_asserts #(
	parameter int unsigned RECALL_CYC = 20,
	parameter int unsigned PROG_CYC = 2100
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic count_enable,
	input wire logic ctl_over_high,
	input wire logic ctl_under_low,
	input wire logic ctl_over_prog,
	input wire logic [ucn_pkg::CODE_W-1:0] dcp_code,
	input wire logic nv_busy,
	input wire logic ctl_mid_bias_en,
	input wire logic ce_pulldown_en
);
	import ucn_pkg::*;
	localparam int RB = RECALL_CYC + 5;
	localparam int PB = PROG_CYC - PROG_HOLD_CYC;
	// a count must trace back to a long excursion
	wire logic exc;
	assign exc = ctl_under_low | ctl_over_high;
	// store busy time is counted: its bound lies beyond a delay range
	logic [31:0] busy_len_r;
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			busy_len_r <= '0;
		end else if (nv_busy) begin
			busy_len_r <= busy_len_r + 1'b1;
		end else begin
			busy_len_r <= '0;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	// nine bits so that a wrap cannot pass as one step
	a_step_one: assert property ($changed(dcp_code) && !nv_busy && !$past(nv_busy) |->
		({1'b0, dcp_code} + 9'h001 == {1'b0, $past(dcp_code)}) || ({1'b0, dcp_code} == {1'b0, $past(dcp_code)} + 9'h001))
		else $error("code moved by other than one step");
	a_hold_idle: assert property (!count_enable && !nv_busy |=> $stable(dcp_code))
		else $error("code moved while counting disabled");
	a_cause_exc: assert property ($changed(dcp_code) && !nv_busy && !$past(nv_busy) |-> $past(exc, 250))
		else $error("code moved without a long excursion");
	a_prog_still: assert property (count_enable && ctl_over_prog && $past(ctl_over_prog, 250) |-> $stable(dcp_code))
		else $error("code moved at programming level");
	a_reload_start: assert property ($fell(count_enable) |-> ##[0:2] nv_busy)
		else $error("reload did not start");
	a_reload_len: assert property ($rose(nv_busy) && !count_enable |-> ##[1:RB] !nv_busy)
		else $error("reload too long");
	a_store_len: assert property (nv_busy && count_enable |-> busy_len_r < PB)
		else $error("store too long");
	a_pwrup_load: assert property ($rose(arst_n) |-> nv_busy ##[1:RB] !nv_busy)
		else $error("power-up load missing or too long");
	a_bias_on: assert property (ctl_mid_bias_en)
		else $error("mid bias off");
	a_pull_low: assert property (ce_pulldown_en)
		else $error("enable pulldown off");
endmodule
bind ucn_core ucn_core_asserts #(.RECALL_CYC(RECALL_CYC), .PROG_CYC(PROG_CYC)) u_asrt (.clk_sys(clk_sys),
	.arst_n(arst_n), .count_enable(count_enable), .ctl_over_high(ctl_over_high), .ctl_under_low(ctl_under_low),
	.ctl_over_prog(ctl_over_prog), .dcp_code(dcp_code), .nv_busy(nv_busy), .ctl_mid_bias_en(ctl_mid_bias_en),
	.ce_pulldown_en(ce_pulldown_en));

// File: dv/ucn_pin_model.sv
`timescale 1ns/1ns
module ucn_pin_model (
	input wire ucn_pkg::ucn_level_t pin_lvl,
	input wire logic pin_drive,
	output logic ctl_over_high,
	output logic ctl_under_low,
	output logic ctl_over_prog
);
	import ucn_pkg::*;
	ucn_level_t seen;
	// a released pin settles at the device's mid bias
	assign seen = pin_drive ? pin_lvl : LVL_MID;
	// programming level also lies above the high threshold
	assign ctl_over_prog = (seen == LVL_PROG);
	assign ctl_over_high = (seen == LVL_HIGH) || (seen == LVL_PROG);
	assign ctl_under_low = (seen == LVL_LOW);
endmodule

// File: dv/tb_updown_counter_nv_store.sv
`timescale 1ns/1ns
module tb_updown_counter_nv_store;
	import ucn_pkg::*;
	localparam int W = 250;
	localparam int PW = 2000;
	logic clk_sys = 0;
	logic arst_n = 0;
	logic count_enable = 0;
	logic pin_drive = 0;
	ucn_level_t pin_lvl = LVL_MID;
	logic oh, ul, op, nv_busy, bias, pd;
	logic [CODE_W-1:0] dcp_code;
	int bad_count = 0;
	int total_checks = 0;
	always #50 clk_sys = ~clk_sys;
	ucn_pin_model u_pin (.pin_lvl(pin_lvl), .pin_drive(pin_drive), .ctl_over_high(oh), .ctl_under_low(ul),
		.ctl_over_prog(op));
	ucn_core #(.RECALL_CYC(20), .PROG_CYC(2100)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
		.count_enable(count_enable), .ctl_over_high(oh), .ctl_under_low(ul), .ctl_over_prog(op),
		.dcp_code(dcp_code), .nv_busy(nv_busy), .ctl_mid_bias_en(bias), .ce_pulldown_en(pd));
	task check(input logic [CODE_W-1:0] seen, input logic [CODE_W-1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// gap of W exceeds the device's count latency, well over the 10 us spacing
	task pulse(input ucn_level_t l, input int w);
		pin_lvl = l;
		pin_drive = 1;
		cyc(w);
		pin_drive = 0;
		pin_lvl = LVL_MID;
		cyc(W);
	endtask
	// inputs stay put while the device is busy
	task idle;
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 3000) begin
			cyc(1);
			n++;
		end
		check({7'h00, nv_busy}, 8'h00);
	endtask
	task enable;
		count_enable = 1;
		cyc(600);
	endtask
	task t_powerup;
		idle();
		check(dcp_code, CODE_FACTORY);
		check({6'h00, bias, pd}, 8'h03);
		$display("t_powerup finished");
	endtask
	task t_count;
		enable();
		pulse(LVL_LOW, PW);
		check(dcp_code, 8'h80);
		pulse(LVL_LOW, PW);
		check(dcp_code, 8'h81);
		pulse(LVL_HIGH, PW);
		check(dcp_code, 8'h80);
		pulse(LVL_LOW, 150);
		pulse(LVL_HIGH, 150);
		check(dcp_code, 8'h80);
		// a swing from rail to rail is not a pulse
		pin_lvl = LVL_LOW;
		pin_drive = 1;
		cyc(W);
		pin_lvl = LVL_HIGH;
		cyc(W);
		pin_drive = 0;
		pin_lvl = LVL_MID;
		cyc(W);
		check(dcp_code, 8'h80);
		count_enable = 0;
		cyc(3);
		idle();
		// two pulses, so the first-pulse discard cannot hide a count
		pulse(LVL_LOW, W);
		pulse(LVL_LOW, W);
		check(dcp_code, 8'h80);
		$display("t_count finished");
	endtask
	task t_store;
		enable();
		pulse(LVL_LOW, W);
		pulse(LVL_LOW, W);
		pulse(LVL_PROG, 2500);
		idle();
		check(dcp_code, 8'h81);
		pulse(LVL_LOW, W);
		check(dcp_code, 8'h81);
		pulse(LVL_HIGH, W);
		check(dcp_code, 8'h80);
		// too short a programming hold must not store
		pulse(LVL_PROG, 1000);
		check(dcp_code, 8'h80);
		count_enable = 0;
		cyc(3);
		idle();
		check(dcp_code, 8'h81);
		$display("t_store finished");
	endtask
	task t_saturate;
		enable();
		pulse(LVL_HIGH, W);
		// one more step than 0x81 needs, so the floor is pressed
		for (int i = 0; i < 130; i++) begin
			pulse(LVL_HIGH, W);
		end
		check(dcp_code, 8'h00);
		pulse(LVL_LOW, W);
		check(dcp_code, 8'h01);
		$display("t_saturate finished");
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		cyc(20);
		arst_n = 1;
		t_powerup();
		t_count();
		t_store();
		t_saturate();
		test_done();
	end
	// about 83k cycles expected
	initial begin
		repeat (95000) @(posedge clk_sys);
		bad_count++;
		test_done();
	end
endmodule
